// ### design/dacr_top.sv
// AHB-Lite slave with channel, range, sample and digital ports
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
module dacr_top
    import dacr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // converter front end
    output logic conv_start,
    output dacr_conv_req_t conv_req,
    output logic [9:0] gain_factor,
    input wire logic conv_done,
    input wire dacr_conv_res_t conv_res,
    // digital ports
    output logic [15:0] output_port_value,
    input wire logic [15:0] input_port_value
);
    // captured address phase
    logic wr_pend_q;
    logic [7:0] addr_q;
    // settings
    logic [4:0] channel_select_value_q;
    logic [1:0] range_q;
    logic scan_q;
    logic high_gain_q;
    logic [15:0] dout_q;
    // held result and its state
    dacr_conv_res_t res_q;
    logic valid_q;
    dacr_seq_t state_q;
    dacr_seq_t state_d;
    // read data register
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // channel from the sequencer
    logic [4:0] chan_cur;

    // decode of the address phase
    wire logic addr_ok;
    wire logic rd_take;
    wire logic wr_take;
    wire logic pop_rd;
    wire logic wr_chan;
    wire logic wr_range;
    wire logic wr_mode;
    wire logic wr_dout;
    wire logic wr_swreset;
    wire logic start_ok;

    assign addr_ok = hsel && hready && (htrans == DACR_HTRANS_NONSEQ);
    assign rd_take = addr_ok && !hwrite;
    assign wr_take = addr_ok && hwrite;
    // reading either sample view consumes the held result
    assign pop_rd = rd_take && ((haddr == DACR_OFF_SAMPLE) ||
        (haddr == DACR_OFF_COMBINED));
    assign wr_chan = wr_pend_q && (addr_q == DACR_OFF_CHANNEL);
    assign wr_range = wr_pend_q && (addr_q == DACR_OFF_RANGE);
    assign wr_mode = wr_pend_q && (addr_q == DACR_OFF_MODE);
    assign wr_dout = wr_pend_q && (addr_q == DACR_OFF_DOUT);
    // software reset only restarts the sequencer, settings stay
    assign wr_swreset = wr_pend_q && (addr_q == DACR_OFF_SWRESET);
    // a new conversion starts only once the last result was read
    assign start_ok = (state_q == DACR_IDLE) && !valid_q && !wr_swreset;

    // read mux, sampled at the address phase
    assign rdata_d =
        (haddr == DACR_OFF_SAMPLE) ? {16'h0000, res_q.sample} :
        (haddr == DACR_OFF_COMBINED) ?
            {11'h000, res_q.chan, res_q.sample} :
        (haddr == DACR_OFF_CHANNEL) ? {27'h0000000, channel_select_value_q} :
        (haddr == DACR_OFF_RANGE) ? {30'h00000000, range_q} :
        (haddr == DACR_OFF_MODE) ? {30'h00000000, high_gain_q, scan_q} :
        (haddr == DACR_OFF_STATUS) ?
            {30'h00000000, (state_q == DACR_WAIT), valid_q} :
        (haddr == DACR_OFF_DOUT) ? {16'h0000, dout_q} :
        (haddr == DACR_OFF_DIN) ? {16'h0000, input_port_value} :
        32'h00000000;

    // sequencer next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            DACR_IDLE:
            begin
                if (start_ok)
                begin
                    state_d = DACR_WAIT;
                end
            end
            DACR_WAIT:
            begin
                // abandon the conversion on software reset
                if (wr_swreset || conv_done)
                begin
                    state_d = DACR_IDLE;
                end
            end
            default:
            begin
                state_d = DACR_IDLE;
            end
        endcase
    end

    // bus always answers at once and OKAY
    assign hreadyout = 1'b1;
    assign hresp = hresp_okay;
    assign hrdata = rdata_q;
    // converter request takes its channel from the sequencer and its gain code from the range setting
    assign conv_start = start_ok;
    assign conv_req.chan = chan_cur;
    assign conv_req.gain_code = range_q;
    assign output_port_value = dout_q;

    // channel sequencer
    dacr_scan_seq u_seq (
        .hclk(hclk),
        .hresetn(hresetn),
        .scan_en(scan_q),
        .chan_reg(channel_select_value_q),
        .step(start_ok),
        .chan_cur(chan_cur)
    );

    // gain table
    dacr_gain_map u_gain (
        .gain_code(range_q),
        .high_gain(high_gain_q),
        .gain_factor(gain_factor)
    );

    // address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            wr_pend_q <= wr_take;
            addr_q <= addr_ok ? haddr : addr_q;
            rdata_q <= rd_take ? rdata_d : rdata_q;
        end
    end

    // settings written by software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            channel_select_value_q <= DACR_CHAN_RST;
            range_q <= DACR_RANGE_RST;
            // scanning off and the high-gain table after reset
            scan_q <= DACR_SCAN_RST;
            high_gain_q <= DACR_HIGH_GAIN_RST;
            dout_q <= DACR_DOUT_RST;
        end
        else
        begin
            if (wr_chan)
            begin
                channel_select_value_q <= hwdata[4:0];
            end
            if (wr_range)
            begin
                range_q <= hwdata[1:0];
            end
            if (wr_mode)
            begin
                scan_q <= hwdata[DACR_MODE_SCAN_BIT];
                high_gain_q <= hwdata[DACR_MODE_VARIANT_BIT];
            end
            if (wr_dout)
            begin
                dout_q <= hwdata[15:0];
            end
        end
    end

    // result holding; a completion beats a read in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= DACR_IDLE;
            valid_q <= 1'b0;
            res_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            if ((state_q == DACR_WAIT) && conv_done && !wr_swreset)
            begin
                valid_q <= 1'b1;
                // two's complement code stored unchanged
                res_q <= conv_res;
            end
            else if (pop_rd)
            begin
                valid_q <= 1'b0;
            end
        end
    end

    // combined word reflects sample and channel
    a_comb_layout: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_take && haddr == DACR_OFF_COMBINED |=>
        hrdata[20:16] == $past(res_q.chan) &&
        hrdata[15:0] == $past(res_q.sample) &&
        hrdata[31:21] == 11'h000)
        else $error("combined word layout wrong");

    // plain sample view holds the code alone, upper half zero
    a_samp_layout: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_take && haddr == DACR_OFF_SAMPLE |=>
        hrdata == {16'h0000, $past(res_q.sample)})
        else $error("sample word layout wrong");

    // range resets to unity, whatever the variant
    a_range_reset: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> range_q == DACR_RANGE_RST &&
        gain_factor == DACR_GAIN_1)
        else $error("range not unity after reset");

    // fixed channel when scanning off
    a_fixed_chan: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !scan_q |-> conv_req.chan == channel_select_value_q)
        else $error("fixed channel not selected");

    // below the last channel the scan moves up by one
    a_scan_bound: assert property (
        @(posedge hclk) disable iff (!hresetn)
        scan_q && conv_start &&
        conv_req.chan < channel_select_value_q |=>
        !scan_q || conv_req.chan == $past(conv_req.chan) + 5'h01)
        else $error("scan skipped a channel");

    // at or past the last channel the scan starts again at zero
    a_scan_wrap: assert property (
        @(posedge hclk) disable iff (!hresetn)
        scan_q && conv_start &&
        conv_req.chan >= channel_select_value_q |=>
        !scan_q || conv_req.chan == 5'h00)
        else $error("scan did not wrap");

    // output port follows a write once its data phase ends
    a_dout_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_take && haddr == DACR_OFF_DOUT |=> ##1
        output_port_value == $past(hwdata[15:0]))
        else $error("output port not updated");

    // input port read is live
    a_din_live: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_take && haddr == DACR_OFF_DIN |=>
        hrdata == {16'h0000, $past(input_port_value)})
        else $error("input port read wrong");

    // reading a sample consumes it
    a_pop_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        pop_rd && !(state_q == DACR_WAIT && conv_done) |=> !valid_q)
        else $error("sample not consumed");

    // an unread result is neither dropped nor overwritten
    a_hold_result: assert property (
        @(posedge hclk) disable iff (!hresetn)
        valid_q && !pop_rd |=> valid_q && $stable(res_q))
        else $error("held result lost");

    // software reset keeps settings
    a_swreset_keep: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_swreset |=> $stable(range_q) && $stable(dout_q) &&
        $stable(channel_select_value_q))
        else $error("settings changed by soft reset");

    // software reset stops the converter but leaves the bus ready
    a_swreset_stop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_swreset |-> !conv_start && hreadyout ##1 state_q == DACR_IDLE)
        else $error("soft reset did not stop converter");
endmodule

// ### design/dacr_pkg.sv
// package of constants and types for the channel, range and port block
// Overview of operation
// - combined word low sixteen bits hold sample
// - combined word bits 16..20 hold channel
// - combined sample and channel register 32 bits
// - samples are 16 bits, bit 0 least significant
// - thirty-two channels numbered 0 to 31
// - scan off: channel register picks the channel
// - scan on: channel register is last scanned
// - range resets to unity gain
// - high-gain variant: gains 1, 10, 100, 1000
// - decimal-gain variant: gains 1, 2, 4, 8
// - output port write drives sixteen outputs
// - input port read returns live inputs
// - software reset keeps settings and bus alive
// - bipolar samples are two's complement
package dacr_pkg;
    // register byte addresses
    localparam logic [7:0] DACR_OFF_SAMPLE = 8'h00;
    localparam logic [7:0] DACR_OFF_COMBINED = 8'h04;
    localparam logic [7:0] DACR_OFF_CHANNEL = 8'h08;
    localparam logic [7:0] DACR_OFF_RANGE = 8'h0c;
    localparam logic [7:0] DACR_OFF_MODE = 8'h10;
    localparam logic [7:0] DACR_OFF_STATUS = 8'h14;
    localparam logic [7:0] DACR_OFF_DOUT = 8'h18;
    localparam logic [7:0] DACR_OFF_DIN = 8'h1c;
    localparam logic [7:0] DACR_OFF_SWRESET = 8'h20;
    // field layout of the combined word
    localparam int DACR_CHAN_LSB = 16;
    localparam int DACR_CHAN_MSB = 20;
    // mode register bits
    localparam int DACR_MODE_SCAN_BIT = 0;
    localparam int DACR_MODE_VARIANT_BIT = 1;
    // status register bits
    localparam int DACR_STAT_VALID_BIT = 0;
    localparam int DACR_STAT_BUSY_BIT = 1;
    // reset values
    localparam logic [4:0] DACR_CHAN_RST = 5'h00;
    localparam logic [1:0] DACR_RANGE_RST = 2'h0;
    localparam logic [15:0] DACR_DOUT_RST = 16'h0000;
    localparam logic DACR_SCAN_RST = 1'b0;
    localparam logic DACR_HIGH_GAIN_RST = 1'b1;
    // gain codes: high-gain variant
    localparam logic [1:0] DACR_HG_X1 = 2'h0;
    localparam logic [1:0] DACR_HG_X10 = 2'h1;
    localparam logic [1:0] DACR_HG_X100 = 2'h2;
    localparam logic [1:0] DACR_HG_X1000 = 2'h3;
    // gain codes: decimal-gain variant
    localparam logic [1:0] DACR_DG_X1 = 2'h0;
    localparam logic [1:0] DACR_DG_X2 = 2'h1;
    localparam logic [1:0] DACR_DG_X4 = 2'h2;
    localparam logic [1:0] DACR_DG_X8 = 2'h3;
    // gain factors sent to the front end
    localparam logic [9:0] DACR_GAIN_1 = 10'h001;
    localparam logic [9:0] DACR_GAIN_2 = 10'h002;
    localparam logic [9:0] DACR_GAIN_4 = 10'h004;
    localparam logic [9:0] DACR_GAIN_8 = 10'h008;
    localparam logic [9:0] DACR_GAIN_10 = 10'h00a;
    localparam logic [9:0] DACR_GAIN_100 = 10'h064;
    localparam logic [9:0] DACR_GAIN_1000 = 10'h3e8;
    // full-scale codes of the bipolar range
    localparam logic [15:0] DACR_CODE_POS_FS = 16'h7fff;
    localparam logic [15:0] DACR_CODE_NEG_FS = 16'h8000;
    // htrans and hresp encodings
    localparam logic [1:0] DACR_HTRANS_NONSEQ = 2'h2;
    localparam logic hresp_okay = 1'b0;
    // converter request and result carriers
    typedef struct packed {
        logic [4:0] chan;
        logic [1:0] gain_code;
    } dacr_conv_req_t;
    typedef struct packed {
        logic [4:0] chan;
        logic [15:0] sample;
    } dacr_conv_res_t;
    // sequencer states
    typedef enum logic [1:0] {
        DACR_IDLE = 2'b00,
        DACR_WAIT = 2'b01
    } dacr_seq_t;
endpackage

// ### design/dacr_gain_map.sv
// maps the range code and variant to a gain factor
`timescale 1ns/1ns
module dacr_gain_map
    import dacr_pkg::*;
(
    // selection
    input wire logic [1:0] gain_code,
    input wire logic high_gain,
    // result
    output logic [9:0] gain_factor
);
    // high-gain table
    wire logic [9:0] hg_factor;
    // decimal-gain table
    wire logic [9:0] dg_factor;

    // powers of ten for the high-gain card
    assign hg_factor = (gain_code == DACR_HG_X1) ? DACR_GAIN_1 :
        (gain_code == DACR_HG_X10) ? DACR_GAIN_10 :
        (gain_code == DACR_HG_X100) ? DACR_GAIN_100 :
        DACR_GAIN_1000;
    // powers of two for the decimal-gain card
    assign dg_factor = (gain_code == DACR_DG_X1) ? DACR_GAIN_1 :
        (gain_code == DACR_DG_X2) ? DACR_GAIN_2 :
        (gain_code == DACR_DG_X4) ? DACR_GAIN_4 :
        DACR_GAIN_8;
    assign gain_factor = high_gain ? hg_factor : dg_factor;
endmodule

// ### design/dacr_scan_seq.sv
// picks the next channel to convert, fixed or scanning
`timescale 1ns/1ns
module dacr_scan_seq
    import dacr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // settings
    input wire logic scan_en,
    input wire logic [4:0] chan_reg,
    // advance after each conversion start
    input wire logic step,
    // channel to convert next
    output logic [4:0] chan_cur
);
    // scan position
    logic [4:0] pos_q;
    logic [4:0] pos_d;

    // wrap to zero after the last channel of the scan
    assign pos_d = !scan_en ? 5'h00 :
        !step ? pos_q :
        (pos_q >= chan_reg) ? 5'h00 : pos_q + 5'h01;
    // fixed channel when scanning is off
    assign chan_cur = scan_en ? pos_q : chan_reg;

    // position register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pos_q <= 5'h00;
        end
        else
        begin
            pos_q <= pos_d;
        end
    end
endmodule

// ### tb/dacr_conv_model.sv
// behavioural converter front end answering conversion requests
`timescale 1ns/1ns
module dacr_conv_model
    import dacr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request side
    input wire logic conv_start,
    input wire dacr_conv_req_t conv_req,
    // bench settings: next sample value and latency
    input wire logic [15:0] samp,
    input wire logic [3:0] lag,
    // result side
    output logic conv_done,
    output dacr_conv_res_t conv_res
);
    logic busy_q; // a conversion is running
    logic [3:0] cnt_q; // cycles left before the result
    logic [4:0] chan_q; // channel taken with the request
    // a new request always restarts, so an aborted one cannot lock us up
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            chan_q <= 5'h00;
            conv_done <= 1'b0;
            conv_res <= '0;
        end
        else
        begin
            conv_done <= 1'b0;
            // result bus is junk outside the done pulse
            conv_res <= ~conv_res;
            if (conv_start)
            begin
                busy_q <= 1'b1;
                chan_q <= conv_req.chan;
                cnt_q <= lag;
            end
            else if (busy_q && cnt_q == 4'h0)
            begin
                busy_q <= 1'b0;
                conv_done <= 1'b1;
                conv_res <= {chan_q, samp};
            end
            else if (busy_q)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

// ### tb/tb_dacr_top.sv
// self-checking bench for the channel, range and port block
`timescale 1ns/1ns
module tb_dacr_top
    import dacr_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, d;
    logic conv_start, conv_done;
    dacr_conv_req_t conv_req;
    dacr_conv_res_t conv_res;
    logic [9:0] gain_factor;
    logic [15:0] output_port_value, input_port_value, samp;
    logic [3:0] lag;
    int error_cnt, num_checks;
    // the one slave's ready is the bus ready
    assign hready = hreadyout;
    dacr_top u_dacr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start),
        .conv_req(conv_req), .gain_factor(gain_factor),
        .conv_done(conv_done), .conv_res(conv_res),
        .output_port_value(output_port_value),
        .input_port_value(input_port_value));
    dacr_conv_model u_dacr_conv_model (.hclk(hclk), .hresetn(hresetn),
        .conv_start(conv_start), .conv_req(conv_req), .samp(samp),
        .lag(lag), .conv_done(conv_done), .conv_res(conv_res));
    // clock at 100 MHz
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // prints counts and the verdict, then stops
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // compares a seen value with the expected one
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // waits for a sampled-high ready, bounded
    task wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask
    // one single word transfer: address phase, then data phase
    task bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
             output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= DACR_HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdat = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(a, 1'b1, v, x);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        bus(a, 1'b0, 32'h0, v);
    endtask
    // polls status until a result is held, bounded
    task wait_valid;
        int n;
        logic [31:0] s;
        n = 0;
        do
        begin
            rd(DACR_OFF_STATUS, s);
            n++;
        end while (s[DACR_STAT_VALID_BIT] !== 1'b1 && n < 100);
        if (s[DACR_STAT_VALID_BIT] !== 1'b1)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task get(input logic [7:0] a, output logic [31:0] v);
        wait_valid();
        rd(a, v);
    endtask
    // register values after reset
    task t_reset;
        rd(DACR_OFF_RANGE, d);
        check(d, 32'h0);
        check({22'h0, gain_factor}, {22'h0, DACR_GAIN_1});
        rd(DACR_OFF_CHANNEL, d);
        check(d, 32'h0);
        rd(DACR_OFF_DOUT, d);
        check({d[15:0], output_port_value}, 32'h0);
    endtask
    // every gain code on both variants
    task t_gain;
        logic [9:0] hg[4];
        logic [9:0] dg[4];
        hg = '{DACR_GAIN_1, DACR_GAIN_10, DACR_GAIN_100, DACR_GAIN_1000};
        dg = '{DACR_GAIN_1, DACR_GAIN_2, DACR_GAIN_4, DACR_GAIN_8};
        for (int v = 0; v < 2; v++)
            for (int c = 0; c < 4; c++)
            begin
                wr(DACR_OFF_MODE, v ? 32'h2 : 32'h0);
                wr(DACR_OFF_RANGE, c);
                @(negedge hclk);
                check(gain_factor, v ? hg[c] : dg[c]);
                check({30'h0, conv_req.gain_code}, c);
            end
    endtask
    // fixed channel, combined word and plain sample
    task t_chan(input logic [4:0] ch, input logic [15:0] s);
        wr(DACR_OFF_CHANNEL, {27'h0, ch});
        rd(DACR_OFF_CHANNEL, d);
        check(d, {27'h0, ch});
        @(posedge hclk) samp <= s;
        get(DACR_OFF_COMBINED, d);
        // the pop starts the next conversion: busy, nothing held
        rd(DACR_OFF_STATUS, d);
        check(d, 32'h1 << DACR_STAT_BUSY_BIT);
        get(DACR_OFF_COMBINED, d);
        check(d, {11'h0, ch, s});
        get(DACR_OFF_SAMPLE, d);
        check(d, {16'h0, s});
    endtask
    // scan walks 0 up to the last channel, then wraps
    task t_scan;
        logic [4:0] prev;
        wr(DACR_OFF_MODE, 32'h1);
        rd(DACR_OFF_MODE, d);
        check(d, 32'h1);
        wr(DACR_OFF_CHANNEL, 32'h2);
        get(DACR_OFF_COMBINED, d);
        get(DACR_OFF_COMBINED, d);
        get(DACR_OFF_COMBINED, d);
        prev = d[20:16];
        repeat (5)
        begin
            get(DACR_OFF_COMBINED, d);
            check(d[20:16], prev == 5'd2 ? 5'd0 : prev + 5'd1);
            prev = d[20:16];
        end
        wr(DACR_OFF_MODE, 32'h0);
    endtask
    // a held result is not overwritten by later samples
    task t_oldest;
        @(posedge hclk) samp <= 16'h1111;
        get(DACR_OFF_SAMPLE, d);
        wait_valid();
        @(posedge hclk) samp <= 16'h2222;
        repeat (20) @(posedge hclk);
        rd(DACR_OFF_SAMPLE, d);
        check(d[15:0], 16'h1111);
        get(DACR_OFF_SAMPLE, d);
        check(d[15:0], 16'h2222);
    endtask
    // digital output drive and live input reads
    task t_ports;
        wr(DACR_OFF_DOUT, 32'ha5c3);
        @(negedge hclk);
        check(output_port_value, 16'ha5c3);
        @(posedge hclk) input_port_value <= 16'h3c5a;
        rd(DACR_OFF_DIN, d);
        check(d, 32'h3c5a);
        @(posedge hclk) input_port_value <= 16'hc3a5;
        rd(DACR_OFF_DIN, d);
        check(d, 32'hc3a5);
    endtask
    // soft reset keeps settings and the bus answering
    task t_swreset;
        wr(DACR_OFF_CHANNEL, 32'h7);
        wr(DACR_OFF_RANGE, 32'h2);
        wr(DACR_OFF_SWRESET, 32'h1);
        rd(DACR_OFF_CHANNEL, d);
        check(d, 32'h7);
        rd(DACR_OFF_RANGE, d);
        check(d, 32'h2);
        check(output_port_value, 16'ha5c3);
        get(DACR_OFF_COMBINED, d);
        get(DACR_OFF_COMBINED, d);
        check(d[20:16], 5'h07);
        rd(8'h40, d);
        check(d, 32'h0);
        check({31'h0, hresp}, {31'h0, hresp_okay});
        wr(DACR_OFF_DIN, 32'hffff);
        rd(DACR_OFF_DIN, d);
        check(d, 32'hc3a5);
    endtask
    // reset in mid-run brings every setting back
    task t_rst_mid;
        wr(DACR_OFF_RANGE, 32'h3);
        wr(DACR_OFF_MODE, 32'h1);
        @(posedge hclk) hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(DACR_OFF_RANGE, d);
        check(d, {30'h0, DACR_RANGE_RST});
        check({22'h0, gain_factor}, {22'h0, DACR_GAIN_1});
        rd(DACR_OFF_MODE, d);
        check(d, {30'h0, DACR_HIGH_GAIN_RST, DACR_SCAN_RST});
        check({16'h0, output_port_value}, {16'h0, DACR_DOUT_RST});
        get(DACR_OFF_COMBINED, d);
        check(d, {11'h0, DACR_CHAN_RST, samp});
    endtask
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        input_port_value = 16'h0000;
        samp = 16'h1234;
        lag = 4'h1;
        error_cnt = 0;
        num_checks = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_gain();
        t_chan(5'd5, DACR_CODE_POS_FS);
        lag <= 4'h9;
        t_chan(5'd31, DACR_CODE_NEG_FS);
        t_scan();
        lag <= 4'h1;
        t_oldest();
        t_ports();
        t_swreset();
        t_rst_mid();
        give_verdict();
    end
endmodule
